// File: logic/epw_pkg.sv
// constants, register map and carrier types of the enhanced pwm output stage
// Summary of operation
// - timebase runs from the system clock only
// - reset makes pins inputs, registers default
// - relocation register moves pins A and B
// - up to four outputs, 10-bit resolution
// - mode field picks single, half, forward, reverse
// - half uses A,B only; full uses all
// - half-bridge: A is pwm, B its complement
// - single mode outputs chosen by steering enables
// - unit mode low bits set pin polarity
// - dead-band delays each half-bridge output's turn-on
// - dead-band above duty keeps output inactive
// - first enable waits for new period
// - main control all zero releases pins
// - unused pins stay free for other functions
// - timebase is count joined with two low bits
// - period match clears count, sets, latches duty
// - duty is high byte plus two low bits
// - timebase equal to shadow duty clears output
// - one dead-band unit is four clocks
package epw_pkg;

    // ------------------------------------------------------------
    // register byte offsets on the wishbone slave
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_PIN_RELOCATION    = 8'h00;
    localparam logic [7:0] OFS_PWM_MAIN_CONTROL  = 8'h04;
    localparam logic [7:0] OFS_DUTY_HIGH_BYTE    = 8'h08;
    localparam logic [7:0] OFS_PERIOD_LIMIT      = 8'h0c;
    localparam logic [7:0] OFS_TIMEBASE_CONTROL  = 8'h10;
    localparam logic [7:0] OFS_TIMEBASE_COUNT    = 8'h14;
    localparam logic [7:0] OFS_DEADBAND_CONTROL  = 8'h18;
    localparam logic [7:0] OFS_STEERING_CONTROL  = 8'h1c;
    localparam logic [7:0] OFS_PORT_A_DIRECTION  = 8'h20;
    localparam logic [7:0] OFS_PORT_C_DIRECTION  = 8'h24;
    localparam logic [7:0] OFS_DUTY_SHADOW       = 8'h28;
    localparam logic [7:0] OFS_IRQ_FLAGS         = 8'h2c;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_PIN_RELOCATION    = 8'h00;
    localparam logic [7:0] RST_PWM_MAIN_CONTROL  = 8'h00;
    localparam logic [7:0] RST_PERIOD_LIMIT      = 8'hff;
    localparam logic [7:0] RST_STEERING_CONTROL  = 8'h01;
    localparam logic [7:0] RST_PORT_DIRECTION    = 8'h3f;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int MODE_SEL_HI      = 7;   // output_mode_sel in main control
    localparam int MODE_SEL_LO      = 6;
    localparam int DUTY_LOW_HI      = 5;   // duty_low_bits in main control
    localparam int DUTY_LOW_LO      = 4;
    localparam int UNIT_MODE_HI     = 3;   // unit_mode_polarity in main control
    localparam int UNIT_MODE_LO     = 2;
    localparam int POL_AC_BIT       = 1;   // 1: outputs A and C active low
    localparam int POL_BD_BIT       = 0;   // 1: outputs B and D active low
    localparam int TB_ON_BIT        = 2;   // timebase control: timer run
    localparam int TB_PRESCALE_HI   = 1;
    localparam int TB_PRESCALE_LO   = 0;
    localparam int TB_POSTSCALE_HI  = 6;
    localparam int TB_POSTSCALE_LO  = 3;
    localparam int RELOC_A_BIT      = 0;   // pin_relocation: A to alternate pin
    localparam int RELOC_B_BIT      = 1;   // pin_relocation: B to alternate pin
    localparam int FLAG_PERIOD_BIT  = 1;   // irq flags: period match seen
    localparam int DIR_A_MAIN_BIT   = 2;   // port A direction bit of A main pin
    localparam int DIR_A_ALT_BIT    = 5;
    localparam int DIR_B_MAIN_BIT   = 0;
    localparam int DIR_B_ALT_BIT    = 4;
    localparam int DIR_C_BIT        = 3;   // port C direction bit of C pin
    localparam int DIR_D_BIT        = 2;

    // ------------------------------------------------------------
    // encodings and timing
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_SINGLE    = 2'h0;
    localparam logic [1:0] MODE_FULL_FWD  = 2'h1;
    localparam logic [1:0] MODE_HALF      = 2'h2;
    localparam logic [1:0] MODE_FULL_REV  = 2'h3;
    localparam logic [1:0] UNIT_PWM       = 2'h3;
    localparam logic [1:0] PRESCALE_1     = 2'h0;
    localparam logic [1:0] PRESCALE_4     = 2'h1;
    localparam int         CLKS_PER_INSN  = 4;   // one instruction cycle
    localparam logic [1:0] LAST_QUARTER   = 2'(CLKS_PER_INSN - 1);
    localparam int         NUM_PINS       = 6;   // A main, A alt, B main, B alt, C, D

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } epw_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } epw_wb_rsp_t;

    typedef struct packed {
        logic [NUM_PINS-1:0] level;
        logic [NUM_PINS-1:0] oe;
    } epw_pins_t;

    typedef struct packed {
        logic [7:0]  pin_relocation;
        logic [7:0]  pwm_main_control;
        logic [7:0]  duty_high_byte;
        logic [7:0]  period_limit;
        logic [7:0]  timebase_control;
        logic [7:0]  timebase_count;
        logic [7:0]  deadband_restart_control;
        logic [7:0]  steering_control;
        logic [7:0]  port_a_direction;
        logic [7:0]  port_c_direction;
        logic [7:0]  duty_shadow;
        logic [1:0]  duty_shadow_low;
        logic [7:0]  irq_flags;
        logic [1:0]  quarter;
        logic [3:0]  prescale;
        logic        running;
        logic        pwm_raw;
        logic [1:0]  want_prev;
        logic [13:0] db_cnt;
        epw_wb_rsp_t rsp;
        epw_pins_t   pins;
    } epw_state_t;

endpackage : epw_pkg

// File: logic/epw_core.sv
// enhanced pwm output stage with wishbone register slave
`timescale 1ns/1ps
module epw_core (
    input  wire logic             clock,
    input  wire logic             rst_b,
    input  wire epw_pkg::epw_wb_req_t wb_req,
    output epw_pkg::epw_wb_rsp_t  wb_rsp,
    output epw_pkg::epw_pins_t    pins
);

    epw_pkg::epw_state_t st;
    epw_pkg::epw_state_t next_st;

    // ------------------------------------------------------------
    // combinational next state
    // ------------------------------------------------------------
    logic        insn_end;
    logic        pre_last;
    logic        tick;
    logic        period_hit;
    logic        pwm_en;
    logic [1:0]  low2;
    logic [9:0]  timebase;
    logic [9:0]  duty10;
    logic [9:0]  shadow10;
    logic [1:0]  out_mode;
    logic        run_pwm;
    logic        live;
    logic [1:0]  want;
    logic [1:0]  db_on;
    logic [6:0]  db_cur;
    logic [6:0]  db_nxt;
    logic [3:0]  act;
    logic [3:0]  used;
    logic [3:0]  lvl;
    logic [3:0]  inv;
    logic [5:0]  pin_sel;
    logic [5:0]  pin_dir;
    logic [5:0]  pin_own;
    logic        wr;
    logic        rd_hit;
    logic [7:0]  rd_byte;
    logic [7:0]  wbyte;

    // timebase, duty compare, steering and pins
    always_comb begin
        next_st = st;
        // quarter counter from the system clock drives the timebase and dead-band below
        next_st.quarter = st.quarter + 2'h1;
        insn_end = (st.quarter == epw_pkg::LAST_QUARTER);
        case (st.timebase_control[epw_pkg::TB_PRESCALE_HI:epw_pkg::TB_PRESCALE_LO])
            epw_pkg::PRESCALE_1: pre_last = 1'b1;
            epw_pkg::PRESCALE_4: pre_last = (st.prescale[1:0] == 2'h3);
            default:             pre_last = (st.prescale == 4'hf);
        endcase
        tick = st.timebase_control[epw_pkg::TB_ON_BIT] && insn_end && pre_last;
        if (st.timebase_control[epw_pkg::TB_ON_BIT] && insn_end) begin
            next_st.prescale = pre_last ? 4'h0 : st.prescale + 4'h1;
        end
        // two low timebase bits from the quarter clock or the prescaler
        case (st.timebase_control[epw_pkg::TB_PRESCALE_HI:epw_pkg::TB_PRESCALE_LO])
            epw_pkg::PRESCALE_1: low2 = st.quarter;
            epw_pkg::PRESCALE_4: low2 = st.prescale[1:0];
            default:             low2 = st.prescale[3:2];
        endcase
        timebase = {st.timebase_count, low2};
        duty10   = {st.duty_high_byte,
                    st.pwm_main_control[epw_pkg::DUTY_LOW_HI:epw_pkg::DUTY_LOW_LO]};
        shadow10 = {st.duty_shadow, st.duty_shadow_low};
        pwm_en   = (st.pwm_main_control[epw_pkg::UNIT_MODE_HI:epw_pkg::UNIT_MODE_LO] == epw_pkg::UNIT_PWM);
        out_mode = st.pwm_main_control[epw_pkg::MODE_SEL_HI:epw_pkg::MODE_SEL_LO];
        period_hit = tick && (st.timebase_count == st.period_limit);

        // timer count and period match
        if (period_hit) begin
            next_st.timebase_count  = 8'h00;
            next_st.duty_shadow     = st.duty_high_byte;
            next_st.duty_shadow_low = duty10[1:0];
            next_st.irq_flags[epw_pkg::FLAG_PERIOD_BIT] = 1'b1;
        end else if (tick) begin
            next_st.timebase_count = st.timebase_count + 8'h01;
        end

        // waveform: set at period start, cleared on duty match
        if (!pwm_en) begin
            next_st.running = 1'b0;
            next_st.pwm_raw = 1'b0;
        end else if (period_hit) begin
            next_st.running = 1'b1;
            next_st.pwm_raw = (duty10 != 10'h000);
        end else if (timebase == shadow10) begin
            next_st.pwm_raw = 1'b0;
        end
        // drop already in the match cycle, so the pulse lasts exactly duty timebase steps
        live    = st.pwm_raw && (timebase != shadow10);
        run_pwm = st.running && live;

        // dead-band on the two half-bridge outputs, each on its own
        want[0] = st.running && (out_mode == epw_pkg::MODE_HALF) && live;
        want[1] = st.running && (out_mode == epw_pkg::MODE_HALF) && !live;
        for (int i = 0; i < 2; i++) begin
            db_cur = st.db_cnt[i*7 +: 7];
            if (!want[i]) begin
                db_nxt = 7'h00;
            end else if (!st.want_prev[i]) begin
                db_nxt = st.deadband_restart_control[6:0];
            end else if (insn_end && (db_cur != 7'h00)) begin
                db_nxt = db_cur - 7'h01;
            end else begin
                db_nxt = db_cur;
            end
            next_st.db_cnt[i*7 +: 7] = db_nxt;
            // a delay longer than the active time never reaches zero in time
            db_on[i] = want[i] && (db_nxt == 7'h00);
        end
        next_st.want_prev = want;

        // logical outputs A..D per mode
        act  = 4'h0;
        used = 4'h0;
        if (pwm_en) begin
            case (out_mode)
                epw_pkg::MODE_SINGLE: begin
                    used = st.steering_control[3:0];
                    act  = st.steering_control[3:0] & {4{run_pwm}};
                end
                epw_pkg::MODE_HALF: begin
                    used = 4'b0011;
                    act  = {2'b00, db_on};
                end
                epw_pkg::MODE_FULL_FWD: begin
                    used = 4'b1111;
                    act  = {run_pwm, 2'b00, st.running};
                end
                epw_pkg::MODE_FULL_REV: begin
                    used = 4'b1111;
                    act  = {1'b0, st.running, run_pwm, 1'b0};
                end
                default: begin
                    used = 4'h0;
                    act  = 4'h0;
                end
            endcase
        end
        inv = {st.pwm_main_control[epw_pkg::POL_BD_BIT], st.pwm_main_control[epw_pkg::POL_AC_BIT],
               st.pwm_main_control[epw_pkg::POL_BD_BIT], st.pwm_main_control[epw_pkg::POL_AC_BIT]};
        lvl = act ^ inv;

        // physical pins: A main/alt, B main/alt, C, D
        pin_sel = {1'b1, 1'b1,
                   st.pin_relocation[epw_pkg::RELOC_B_BIT], !st.pin_relocation[epw_pkg::RELOC_B_BIT],
                   st.pin_relocation[epw_pkg::RELOC_A_BIT], !st.pin_relocation[epw_pkg::RELOC_A_BIT]};
        pin_dir = {st.port_c_direction[epw_pkg::DIR_D_BIT], st.port_c_direction[epw_pkg::DIR_C_BIT],
                   st.port_a_direction[epw_pkg::DIR_B_ALT_BIT], st.port_a_direction[epw_pkg::DIR_B_MAIN_BIT],
                   st.port_a_direction[epw_pkg::DIR_A_ALT_BIT], st.port_a_direction[epw_pkg::DIR_A_MAIN_BIT]};
        pin_own = {used[3], used[2], used[1], used[1], used[0], used[0]};
        // unused or input-direction pins are left undriven for other functions
        next_st.pins.oe    = pin_sel & pin_own & ~pin_dir;
        next_st.pins.level = {lvl[3], lvl[2], lvl[1], lvl[1], lvl[0], lvl[0]} & next_st.pins.oe;

        // wishbone slave: one wait state, ack for one cycle
        wr    = wb_req.cyc && wb_req.stb && wb_req.we && !st.rsp.ack && wb_req.sel[0];
        wbyte = wb_req.dat[7:0];
        next_st.rsp.ack = wb_req.cyc && wb_req.stb && !st.rsp.ack;
        rd_hit  = 1'b1;
        rd_byte = 8'h00;
        case (wb_req.adr)
            epw_pkg::OFS_PIN_RELOCATION:   rd_byte = st.pin_relocation;
            epw_pkg::OFS_PWM_MAIN_CONTROL: rd_byte = st.pwm_main_control;
            epw_pkg::OFS_DUTY_HIGH_BYTE:   rd_byte = st.duty_high_byte;
            epw_pkg::OFS_PERIOD_LIMIT:     rd_byte = st.period_limit;
            epw_pkg::OFS_TIMEBASE_CONTROL: rd_byte = {1'b0, st.timebase_control[6:0]};
            epw_pkg::OFS_TIMEBASE_COUNT:   rd_byte = st.timebase_count;
            epw_pkg::OFS_DEADBAND_CONTROL: rd_byte = st.deadband_restart_control;
            epw_pkg::OFS_STEERING_CONTROL: rd_byte = {4'h0, st.steering_control[3:0]};
            epw_pkg::OFS_PORT_A_DIRECTION: rd_byte = {2'b00, st.port_a_direction[5:0]};
            epw_pkg::OFS_PORT_C_DIRECTION: rd_byte = {2'b00, st.port_c_direction[5:0]};
            epw_pkg::OFS_DUTY_SHADOW:      rd_byte = st.duty_shadow;
            epw_pkg::OFS_IRQ_FLAGS:        rd_byte = st.irq_flags;
            default:                       rd_hit  = 1'b0;
        endcase
        next_st.rsp.dat = (next_st.rsp.ack && rd_hit) ? {24'h000000, rd_byte} : 32'h00000000;
        if (wr) begin
            case (wb_req.adr)
                epw_pkg::OFS_PIN_RELOCATION:   next_st.pin_relocation   = wbyte;
                epw_pkg::OFS_PWM_MAIN_CONTROL: next_st.pwm_main_control = wbyte;
                epw_pkg::OFS_DUTY_HIGH_BYTE:   next_st.duty_high_byte   = wbyte;
                epw_pkg::OFS_PERIOD_LIMIT:     next_st.period_limit     = wbyte;
                epw_pkg::OFS_TIMEBASE_CONTROL: next_st.timebase_control = {1'b0, wbyte[6:0]};
                epw_pkg::OFS_TIMEBASE_COUNT: begin
                    next_st.timebase_count = wbyte;
                    next_st.prescale       = 4'h0;                    // count write restarts prescaler
                end
                epw_pkg::OFS_DEADBAND_CONTROL: next_st.deadband_restart_control = wbyte;
                epw_pkg::OFS_STEERING_CONTROL: next_st.steering_control = {4'h0, wbyte[3:0]};
                epw_pkg::OFS_PORT_A_DIRECTION: next_st.port_a_direction = {2'b00, wbyte[5:0]};
                epw_pkg::OFS_PORT_C_DIRECTION: next_st.port_c_direction = {2'b00, wbyte[5:0]};
                epw_pkg::OFS_IRQ_FLAGS: begin
                    // a period match in the same cycle wins over the clear
                    next_st.irq_flags = wbyte;
                    next_st.irq_flags[epw_pkg::FLAG_PERIOD_BIT] = wbyte[epw_pkg::FLAG_PERIOD_BIT] || period_hit;
                end
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st                          <= '0;
            st.pin_relocation           <= epw_pkg::RST_PIN_RELOCATION;
            st.pwm_main_control         <= epw_pkg::RST_PWM_MAIN_CONTROL;
            st.period_limit             <= epw_pkg::RST_PERIOD_LIMIT;
            st.steering_control         <= epw_pkg::RST_STEERING_CONTROL;
            st.port_a_direction         <= epw_pkg::RST_PORT_DIRECTION;
            st.port_c_direction         <= epw_pkg::RST_PORT_DIRECTION;
        end else begin
            st <= next_st;
        end
    end

    assign wb_rsp = st.rsp;
    assign pins   = st.pins;

endmodule : epw_core

// File: dv/epw_bridge_model.sv
// power switch drivers on the far side of the pwm pins
`timescale 1ns/1ps
module epw_bridge_model (
    input  wire logic              clock,
    input  wire epw_pkg::epw_pins_t pins,
    output logic [5:0]             gate,
    output int                     shoot
);
    // a released pin is pulled down, so its switch stays off
    assign gate = pins.level & pins.oe;
    int overlap = 0;
    assign shoot = overlap;
    // count cycles where both switches of the a/b leg conduct
    always @(posedge clock) begin
        if ((|gate[1:0]) && (|gate[3:2])) overlap <= overlap + 1;
    end
endmodule : epw_bridge_model

// File: dv/epw_core_checker.sv
// port assertions of the pwm output stage
`timescale 1ns/1ps
module epw_core_checker (
    input wire logic                 clock,
    input wire logic                 rst_b,
    input wire epw_pkg::epw_wb_req_t wb_req,
    input wire epw_pkg::epw_wb_rsp_t wb_rsp,
    input wire epw_pkg::epw_pins_t   pins
);
    logic [7:0] ctl;
    logic       req;
    logic       hb;
    // request present and half-bridge selected
    assign req = wb_req.cyc & wb_req.stb;
    assign hb  = ctl[7:6] == epw_pkg::MODE_HALF;
    // copy of main control, taken when the write is acknowledged
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) ctl <= 8'h00;
        else if (wb_rsp.ack && wb_req.we && wb_req.sel[0] && wb_req.adr == epw_pkg::OFS_PWM_MAIN_CONTROL)
            ctl <= wb_req.dat[7:0];
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    a_ack_follows_req: assert property (req && !wb_rsp.ack |=> wb_rsp.ack)
        else $error("request not acknowledged next cycle");
    a_ack_one_pulse: assert property (wb_rsp.ack |=> !wb_rsp.ack)
        else $error("ack longer than one cycle");
    a_ack_has_cause: assert property (wb_rsp.ack |-> $past(req))
        else $error("ack without request");
    a_rdat_idle_zero: assert property (!wb_rsp.ack |-> wb_rsp.dat == 32'h0)
        else $error("read data outside ack");
    a_level_only_driven: assert property ((pins.level & ~pins.oe) == 6'h00)
        else $error("level high on released pin");
    a_unit_off_release: assert property (ctl[3:2] != epw_pkg::UNIT_PWM |-> pins.oe == 6'h00)
        else $error("pin driven while pwm off");
    a_half_cd_free: assert property (hb |-> pins.oe[5:4] == 2'b00)
        else $error("c or d driven in half bridge");
    a_half_no_overlap: assert property (hb && ctl[1:0] == 2'b00 |-> !(|pins.level[1:0] && |pins.level[3:2]))
        else $error("a and b active together");
    cover property (hb && pins.level[0]);
    cover property (ctl[7:6] == epw_pkg::MODE_FULL_FWD && pins.level[5]);
    cover property (wb_rsp.ack && !wb_req.we);
endmodule : epw_core_checker
bind epw_core epw_core_checker u_chk (.clock(clock), .rst_b(rst_b), .wb_req(wb_req), .wb_rsp(wb_rsp), .pins(pins));

// File: dv/enhanced_pwm_output_modes_tb_top.sv
// self-checking bench of the pwm output stage
`timescale 1ns/1ps
module enhanced_pwm_output_modes_tb_top;
    logic                 clock;
    logic                 rst_b;
    epw_pkg::epw_wb_req_t wb_req;
    epw_pkg::epw_wb_rsp_t wb_rsp;
    epw_pkg::epw_pins_t   pins;
    logic [5:0]           gate;
    int                   shoot;
    int                   mismatches;
    int                   checked;
    int                   cnt[6];
    int                   sh;
    int                   p;
    int                   ps;
    int                   duty;
    int                   per;
    int                   e;
    logic [31:0]          seed;
    logic [7:0]           q;
    logic [7:0]           ofs[13] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24,
                                      8'h28, 8'h2c, 8'h30};
    logic [7:0]           rv[13]  = '{8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h01, 8'h3f, 8'h3f,
                                      8'h00, 8'h00, 8'h00};
    logic [7:0]           mc[4]   = '{8'h0c, 8'h8c, 8'h4c, 8'hcc}; // single, half, forward, reverse
    logic [7:0]           ex[4]   = '{8'h55, 8'h09, 8'h43, 8'h34}; // 2 bits per pin a..d: off,duty,comp,full
    int                   idx[4]  = '{0, 2, 4, 5};

    epw_core u_dut (.clock(clock), .rst_b(rst_b), .wb_req(wb_req), .wb_rsp(wb_rsp), .pins(pins));
    epw_bridge_model u_far (.clock(clock), .pins(pins), .gate(gate), .shoot(shoot));

    // 40 mhz system clock
    always #12.5 clock = ~clock;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // expected active clocks per period: duty scaled by prescale, capped at the period
    function automatic int pulse(input int d, input int pr, input int s);
        int w;
        w = d * (s == 0 ? 1 : (s == 1 ? 4 : 16));
        return (w > pr) ? pr : w;
    endfunction : pulse

    task automatic end_sim();
        $display("compared %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: value %h, expected %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_cnt(input int got, input int lo, input int hi);
        checked++;
        if (got < lo || got > hi) begin
            mismatches++;
            $display("mismatch at %0t: count %0d, expected %0d..%0d", $time, got, lo, hi);
        end
    endtask : chk_cnt

    // one classic wishbone cycle; read data lands in q
    task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] d);
        int n;
        @(posedge clock);
        wb_req <= '{1'b1, 1'b1, we, adr, 4'h1, {24'h0, d}};
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (wb_rsp.ack !== 1'b1 && n < 16);
        if (n >= 16) begin
            mismatches++;
            $display("mismatch at %0t: no ack", $time);
            end_sim();
        end else begin
            q = wb_rsp.dat[7:0];
            wb_req <= '0;
        end
    endtask : wb

    // let the waveform settle, then count active clocks and overlaps over one period
    task automatic measure();
        repeat (3 * per) @(posedge clock);
        cnt = '{default: 0};
        sh = shoot;
        repeat (per) begin
            @(posedge clock);
            for (int i = 0; i < 6; i++) cnt[i] += int'(gate[i] === 1'b1);
        end
        sh = shoot - sh;
    endtask : measure

    task automatic setup(input int pl, input int s, input int d, input logic [7:0] m, input logic [7:0] st,
                         input logic [7:0] db);
        wb(1'b1, epw_pkg::OFS_PERIOD_LIMIT, 8'(pl));
        wb(1'b1, epw_pkg::OFS_STEERING_CONTROL, st);
        wb(1'b1, epw_pkg::OFS_DEADBAND_CONTROL, db);
        wb(1'b1, epw_pkg::OFS_DUTY_HIGH_BYTE, 8'(d >> 2));
        wb(1'b1, epw_pkg::OFS_PWM_MAIN_CONTROL, {m[7:6], 2'(d), m[3:0]});
        wb(1'b1, epw_pkg::OFS_TIMEBASE_COUNT, 8'h00);
        wb(1'b1, epw_pkg::OFS_TIMEBASE_CONTROL, {5'h00, 1'b1, 2'(s)});
        per = 4 * (pl + 1) * (s == 0 ? 1 : (s == 1 ? 4 : 16));
        measure();
    endtask : setup

    initial begin
        clock = 1'b0;
        rst_b = 1'b0;
        wb_req = '0;
        seed = 32'h57c24eaa;
        mismatches = 0;
        checked = 0;
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        // reset values of every register, unmapped word last
        foreach (ofs[i]) begin
            wb(1'b0, ofs[i], 8'h00);
            chk_reg(q, rv[i]);
        end
        // read-only shadow and unmapped word drop writes
        wb(1'b1, 8'h28, 8'h5a);
        wb(1'b1, 8'h30, 8'ha5);
        wb(1'b0, 8'h28, 8'h00);
        chk_reg(q, 8'h00);
        wb(1'b0, 8'h30, 8'h00);
        chk_reg(q, 8'h00);
        $display("test registers done");
        wb(1'b1, epw_pkg::OFS_PORT_A_DIRECTION, 8'h00);
        wb(1'b1, epw_pkg::OFS_PORT_C_DIRECTION, 8'h00);
        // random single-output waveforms, both polarities, zero and over-period duty
        for (int k = 0; k < 6; k++) begin
            p = 3 + int'(rnd() % 6);
            ps = (k < 3) ? k : int'(rnd() % 3);
            duty = (k == 0) ? 0 : int'(rnd() % (4 * p + 12));
            setup(p, ps, duty, {4'h0, 2'h3, 1'(k), 1'b0}, 8'h01, 8'h00);
            e = pulse(duty, per, ps);
            chk_cnt(k[0] ? per - cnt[0] : cnt[0], e, e);
        end
        wb(1'b0, epw_pkg::OFS_IRQ_FLAGS, 8'h00);
        chk_reg(q & 8'h02, 8'h02);
        $display("test single waveforms done");
        // pin usage of each output mode
        for (int m = 0; m < 4; m++) begin
            setup(7, 0, 12, mc[m], 8'h0f, 8'h00);
            for (int j = 0; j < 4; j++) begin
                e = (ex[m] >> (2 * j)) & 3;
                e = (e == 0) ? 0 : (e == 1) ? 12 : (e == 2) ? per - 12 : per;
                chk_cnt(cnt[idx[j]], e, e);
            end
            if (m == 1) chk_cnt(sh, 0, 0);
        end
        $display("test output modes done");
        // dead band delays each turn-on, and swallows a too-short phase
        setup(15, 0, 40, 8'h8c, 8'h01, 8'h03);
        chk_cnt(cnt[0], 28, 31);
        chk_cnt(cnt[2], 12, 15);
        chk_cnt(sh, 0, 0);
        setup(15, 0, 40, 8'h8c, 8'h01, 8'h0b);
        chk_cnt(cnt[0], 0, 0);
        chk_cnt(cnt[2], 0, 0);
        $display("test dead band done");
        // output a moved to its alternate pin
        wb(1'b1, epw_pkg::OFS_PIN_RELOCATION, 8'h01);
        setup(7, 0, 12, 8'h0c, 8'h01, 8'h00);
        chk_cnt(cnt[1], 12, 12);
        chk_cnt(cnt[0], 0, 0);
        // direction bit set keeps the pin released
        wb(1'b1, epw_pkg::OFS_PORT_A_DIRECTION, 8'h20);
        repeat (2) @(posedge clock);
        chk_reg({7'h00, pins.oe[1]}, 8'h00);
        // clearing main control releases every pin
        wb(1'b1, epw_pkg::OFS_PWM_MAIN_CONTROL, 8'h00);
        repeat (2) @(posedge clock);
        chk_reg({2'h0, pins.oe}, 8'h00);
        // reset in mid-run restores defaults
        wb(1'b1, epw_pkg::OFS_PORT_A_DIRECTION, 8'h00);
        setup(7, 0, 12, 8'h8c, 8'h01, 8'h00);
        rst_b <= 1'b0;
        repeat (2) @(posedge clock);
        chk_reg({2'h0, pins.oe}, 8'h00);
        rst_b <= 1'b1;
        wb(1'b0, epw_pkg::OFS_PIN_RELOCATION, 8'h00);
        chk_reg(q, 8'h00);
        $display("test release and reset done");
        end_sim();
    end

    // cut a hang short
    initial begin
        repeat (100000) @(posedge clock);
        mismatches++;
        end_sim();
    end
endmodule : enhanced_pwm_output_modes_tb_top
